/* src/serial_irq_pkg.sv */
// Shared constants, types and helpers for the serial interrupt bus
package serial_irq_pkg;

  // Cycle numbers of the remote read message
  localparam logic [5:0] CYC_ARB        = 6'h01; // Normal arbitration
  localparam logic [5:0] CYC_ID_LAST    = 6'h05; // Last contender id cycle
  localparam logic [5:0] CYC_DM         = 6'h06; // Dest mode, mode bit 2
  localparam logic [5:0] CYC_MODE       = 6'h07; // Mode bits 1 and 0
  localparam logic [5:0] CYC_LVL        = 6'h08; // Level, trigger mode
  localparam logic [5:0] CYC_VEC_FIRST  = 6'h09; // First vector pair
  localparam logic [5:0] CYC_DEST_FIRST = 6'h0D; // First destination pair
  localparam logic [5:0] CYC_DEST_LAST  = 6'h10; // Last destination pair
  localparam logic [5:0] CYC_HCK        = 6'h11; // Header checksum
  localparam logic [5:0] CYC_POST       = 6'h12; // Postamble
  localparam logic [5:0] CYC_STAT0      = 6'h13; // Status cycle 0
  localparam logic [5:0] CYC_STAT1      = 6'h14; // Status cycle 1
  localparam logic [5:0] CYC_DATA_FIRST = 6'h15; // First data pair
  localparam logic [5:0] CYC_DATA_LAST  = 6'h24; // Last data pair
  localparam logic [5:0] CYC_DSTAT      = 6'h25; // Data status
  localparam logic [5:0] CYC_DCK        = 6'h26; // Data checksum
  localparam logic [5:0] CYC_IDLE       = 6'h27; // Closing idle cycle

  // Line levels, bit 1 on the left
  localparam logic [1:0] LINES_ARB      = 2'h2; // Arbitration start
  localparam logic [1:0] LINES_IDLE     = 2'h3; // Nobody pulls low

  // Status values
  localparam logic [1:0] STAT_OK        = 2'h3; // Header checksum good
  localparam logic [1:0] STAT_CKERR     = 2'h0; // Header checksum error
  localparam logic [1:0] DSTAT_VALID    = 2'h0; // Returned data valid
  localparam logic [1:0] DSTAT_INVALID  = 2'h3; // Returned data invalid

  // Redirection entry field positions
  localparam int ENT_VEC_LSB  = 0;  // Vector 7:0
  localparam int ENT_MODE_LSB = 8;  // Delivery mode 10:8
  localparam int ENT_DM_BIT   = 11; // Destination mode
  localparam int ENT_LVL_BIT  = 14; // Level
  localparam int ENT_TM_BIT   = 15; // Trigger mode
  localparam int ENT_DEST_LSB = 56; // Destination 63:56

  // Interrupt input count
  localparam int NUM_IRQ = 24;

  // Device link states
  typedef enum logic [2:0] {
    L_IDLE = 3'h1,
    L_SEND = 3'h2,
    L_RECV = 3'h4
  } dev_state_t;

  // Responder states
  typedef enum logic [1:0] {
    H_IDLE = 2'h1,
    H_RUN  = 2'h2
  } host_state_t;

  // Running two-bit header checksum
  function automatic logic [1:0] ck_add(input logic [1:0] acc,
                                        input logic [1:0] pair);
    ck_add = acc + pair;
  endfunction : ck_add

  // Uninverted bit pair of a header cycle, bit 1 on the left
  function automatic logic [1:0] hdr_pair(input logic [63:0] e,
                                          input logic [5:0]  c);
    logic [1:0] k;
    k = 2'h0;
    hdr_pair = 2'h0;
    case (c)
      CYC_DM:   hdr_pair = {e[ENT_DM_BIT], e[ENT_MODE_LSB+2]};
      CYC_MODE: hdr_pair = {e[ENT_MODE_LSB+1], e[ENT_MODE_LSB]};
      CYC_LVL:  hdr_pair = {e[ENT_LVL_BIT], e[ENT_TM_BIT]};
      default: begin
        if (c >= CYC_DEST_FIRST) begin
          k = 2'(c - CYC_DEST_FIRST);
          hdr_pair = e[ENT_DEST_LSB + 7 - 2 * int'(k) -: 2];
        end else if (c >= CYC_VEC_FIRST) begin
          k = 2'(c - CYC_VEC_FIRST);
          hdr_pair = e[ENT_VEC_LSB + 7 - 2 * int'(k) -: 2];
        end
      end
    endcase
  endfunction : hdr_pair

endpackage : serial_irq_pkg

/* src/serial_irq_link_if.sv */
// Two-line wired serial interrupt bus joining the two ends
`timescale 1ns/1ps
interface serial_irq_link_if (
  input wire logic serial_irq_bus_clock  // Bus clock, made by the bench
);
  logic [1:0] dev_out;          // Device drive level, bit 1 = line1
  logic [1:0] dev_oe;           // Device drive enable, high = driving
  logic [1:0] host_out;         // Responder drive level
  logic [1:0] host_oe;          // Responder drive enable
  logic       serial_irq_line0; // Wired level of line 0
  logic       serial_irq_line1; // Wired level of line 1

  // A line reads low when any enabled driver pulls it low
  assign serial_irq_line0 = ~((dev_oe[0] & ~dev_out[0]) |
                              (host_oe[0] & ~host_out[0]));
  assign serial_irq_line1 = ~((dev_oe[1] & ~dev_out[1]) |
                              (host_oe[1] & ~host_out[1]));

  modport device (input serial_irq_bus_clock, input serial_irq_line0,
                  input serial_irq_line1, output dev_out, output dev_oe);
  modport host (input serial_irq_bus_clock, input serial_irq_line0,
                input serial_irq_line1, output host_out, output host_oe);
endinterface : serial_irq_link_if

/* src/serial_irq_sync2.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module serial_irq_sync2 #(
  parameter int W = 1                 // Bits carried
) (
  input  wire logic         clk,      // Receiving clock
  input  wire logic         reset_n,  // Async reset, active low
  input  wire logic [W-1:0] d,        // Level from another domain
  output logic      [W-1:0] q         // Synchronised level
);
  // Both stages of the chain
  typedef struct packed {
    logic [W-1:0] meta;   // First stage, read only by the second
    logic [W-1:0] stable; // Second stage
  } sync_t;

  sync_t r;      // Registered state
  sync_t next_r; // Next state

  // Shift the level through two stages
  always_comb begin
    next_r.meta   = d;
    next_r.stable = r.meta;
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.stable;
endmodule : serial_irq_sync2

/* src/serial_irq_dev_end.sv */
// Remote read initiator and boot interrupt combiner, device end
`timescale 1ns/1ps
// Overview of operation
// - Arbitration cycle, then four contender id cycles
// - Cycles 6, 7 carry inverted mode bits
// - Cycle 8 carries inverted level and trigger
// - Cycles 9-12 carry inverted vector, MSB first
// - Cycles 13-16 carry inverted destination, MSB first
// - Cycle 17 inverted checksum, 18 postamble
// - Responder returns data in cycles 21-36
// - Cycle 37 data status: 00 valid, 11 invalid
// - Cycle 38 data checksum, 39 idle
// - Remote read never retried, always completes
// - Masked low inputs pull boot interrupt low
// - Unmasked inputs never reach boot interrupt
// - Status 11 checksum good, 00 checksum error
module serial_irq_dev_end
  import serial_irq_pkg::*;
(
  input  wire logic         mclk,              // Core clock
  input  wire logic         reset_n,           // Async reset, active low
  serial_irq_link_if.device link,              // Serial bus side
  input  wire logic         rr_start,          // Pulse: start remote read
  input  wire logic [63:0]  rr_entry,          // Redirection entry to send
  input  wire logic [3:0]   rr_arb_id,         // Own bus_contender_id
  output logic              rr_busy,           // Remote read in progress
  output logic              rr_done,           // Pulse: read finished
  output logic [31:0]       rr_data,           // Returned register value
  output logic              rr_data_valid,     // Returned value usable
  output logic [1:0]        rr_hdr_status,     // Status cycle 0 value
  input  wire logic [23:0]  irq_in,            // Interrupt pins, low active
  input  wire logic [23:0]  irq_mask,          // Mask bits, high = masked
  output logic              legacy_boot_irq_n  // Boot interrupt, low active
);

  // Core clock state
  typedef struct packed {
    logic        busy;      // Read outstanding
    logic        req_tgl;   // Request toggle to the link side
    logic        done_seen; // Last completion toggle taken
    logic        done;      // Completion pulse
    logic [31:0] data;      // Captured data
    logic        valid;     // Captured validity
    logic [1:0]  hdr_stat;  // Captured header status
    logic [63:0] entry;     // Entry held for the link side
    logic [3:0]  arb;       // Contender id held for the link side
    logic        boot_n;    // Boot interrupt output
  } core_t;

  // Link clock state
  typedef struct packed {
    dev_state_t  st;        // Sequencer state
    logic [5:0]  cyc;       // Message cycle now on the bus
    logic [1:0]  oe;        // Pull-low enables
    logic [1:0]  hck;       // Header checksum so far
    logic        req_seen;  // Last request toggle taken
    logic        done_tgl;  // Completion toggle to the core side
    logic [1:0]  astat;     // Status cycle 0 value
    logic [31:0] data;      // Data shifted in
    logic        dpar;      // Parity of data shifted in
    logic [1:0]  dstat;     // Data status as seen
    logic        dck_ok;    // Data checksum matched
  } lnk_t;

  core_t       m;       // Core registers
  core_t       next_m;  // Core next state
  lnk_t        l;       // Link registers
  lnk_t        next_l;  // Link next state
  logic        req_s;   // Request toggle in link domain
  logic        done_s;  // Completion toggle in core domain
  logic [23:0] irq_s;   // Synchronised interrupt pins
  logic [1:0]  lines;   // Both wired lines, line1 on the left

  assign lines = {link.serial_irq_line1, link.serial_irq_line0};

  // Request toggle into the bus clock domain
  serial_irq_sync2 #(.W(1)) u_req_sync (
    .clk     (link.serial_irq_bus_clock),
    .reset_n (reset_n),
    .d       (m.req_tgl),
    .q       (req_s)
  );

  // Completion toggle back into the core domain
  serial_irq_sync2 #(.W(1)) u_done_sync (
    .clk     (mclk),
    .reset_n (reset_n),
    .d       (l.done_tgl),
    .q       (done_s)
  );

  // Interrupt pins into the core domain
  serial_irq_sync2 #(.W(NUM_IRQ)) u_irq_sync (
    .clk     (mclk),
    .reset_n (reset_n),
    .d       (irq_in),
    .q       (irq_s)
  );

  // Core side: request handshake, result capture, boot interrupt
  always_comb begin
    next_m      = m;
    next_m.done = 1'b0;
    if (done_s != m.done_seen) begin
      // Finished either way; the read is never retried
      next_m.done_seen = done_s;
      next_m.busy      = 1'b0;
      next_m.done      = 1'b1;
      next_m.data      = l.data;
      next_m.hdr_stat  = l.astat;
      // Good only with good header, valid status and checksum
      next_m.valid     = (l.astat == STAT_OK) &&
                         (l.dstat == DSTAT_VALID) &&
                         l.dck_ok;
    end else if (rr_start && !m.busy) begin
      // Hold entry and id stable for the link side
      next_m.busy    = 1'b1;
      next_m.req_tgl = ~m.req_tgl;
      next_m.entry   = rr_entry;
      next_m.arb     = rr_arb_id;
    end
    // Masked and low inputs pull the output low
    next_m.boot_n = &(irq_s | ~irq_mask);
  end

  // Link side: send header, then listen to the reply
  always_comb begin
    logic [5:0] nc; // Cycle about to start
    logic [1:0] p;  // Uninverted header pair
    logic [1:0] v;  // Level to present on the lines
    logic [1:0] k;  // Contender id bit index
    nc     = l.cyc + 6'h01;
    p      = 2'h0;
    v      = LINES_IDLE;
    k      = 2'h0;
    next_l = l;
    case (l.st)
      L_IDLE: begin
        // Start when the request toggle moves
        if (req_s != l.req_seen) begin
          next_l.req_seen = req_s;
          next_l.cyc      = CYC_ARB;
          next_l.hck      = 2'h0;
          next_l.dpar     = 1'b0;
          next_l.data     = 32'h0;
          next_l.oe       = ~LINES_ARB;
          next_l.st       = L_SEND;
        end else begin
          next_l.oe = 2'h0;
        end
      end
      L_SEND: begin
        next_l.cyc = nc;
        if (nc <= CYC_ID_LAST) begin
          // Id on line 1, most significant bit first
          k = 2'(CYC_ID_LAST - nc);
          v = {m.arb[k], 1'b1};
        end else if (nc <= CYC_DEST_LAST) begin
          // Header fields go out inverted
          p          = hdr_pair(m.entry, nc);
          v          = ~p;
          next_l.hck = ck_add(l.hck, p);
        end else if (nc == CYC_HCK) begin
          v = ~l.hck;
        end else begin
          // Postamble, then let go of the lines
          v         = LINES_IDLE;
          next_l.st = L_RECV;
        end
        // Open drain: enable wherever the line must read low
        next_l.oe = ~v;
      end
      L_RECV: begin
        next_l.cyc = nc;
        next_l.oe  = 2'h0;
        if (l.cyc == CYC_STAT0) begin
          // Lines carry the inverted status
          next_l.astat = ~lines;
        end
        if (l.cyc >= CYC_DATA_FIRST && l.cyc <= CYC_DATA_LAST) begin
          // Two data bits per cycle, high pair first
          next_l.data = {l.data[29:0], lines};
          next_l.dpar = l.dpar ^ (^lines);
        end
        if (l.cyc == CYC_DSTAT) begin
          next_l.dstat = lines;
        end
        if (l.cyc == CYC_DCK) begin
          next_l.dck_ok = (lines == {2{l.dpar}});
        end
        if (l.cyc == CYC_IDLE) begin
          // Complete regardless of what came back
          next_l.st       = L_IDLE;
          next_l.cyc      = 6'h00;
          next_l.done_tgl = ~l.done_tgl;
        end
      end
      default: begin
        next_l.st = L_IDLE;
        next_l.oe = 2'h0;
      end
    endcase
  end

  // Core registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      m <= '{boot_n: 1'b1, default: '0};
    end else begin
      m <= next_m;
    end
  end

  // Link registers
  always_ff @(posedge link.serial_irq_bus_clock or negedge reset_n) begin
    if (!reset_n) begin
      l <= '{st: L_IDLE, default: '0};
    end else begin
      l <= next_l;
    end
  end

  // Outputs straight from registers
  assign link.dev_oe       = l.oe;
  assign link.dev_out      = 2'h0;
  assign rr_busy           = m.busy;
  assign rr_done           = m.done;
  assign rr_data           = m.data;
  assign rr_data_valid     = m.valid;
  assign rr_hdr_status     = m.hdr_stat;
  assign legacy_boot_irq_n = m.boot_n;

endmodule : serial_irq_dev_end

/* src/serial_irq_host_end.sv */
// Remote read responder, the processor controller end
`timescale 1ns/1ps
module serial_irq_host_end
  import serial_irq_pkg::*;
(
  input  wire logic        reset_n,     // Async reset, active low
  serial_irq_link_if.host  link,        // Serial bus side
  input  wire logic [7:0]  my_id,       // Own destination id
  input  wire logic [31:0] reg_value,   // Register value to return
  input  wire logic        reg_valid,   // Register value is valid
  output logic             read_req,    // Pulse: read addressed to us
  output logic [7:0]       req_vector,  // Vector field of the request
  output logic             hdr_error    // Pulse: header checksum bad
);

  // Responder state
  typedef struct packed {
    host_state_t st;         // Sequencer state
    logic [5:0]  cyc;        // Last cycle sampled
    logic [1:0]  oe;         // Pull-low enables
    logic [21:0] hdr;        // Header pairs, uninverted
    logic [1:0]  hck;        // Header checksum so far
    logic        ck_ok;      // Header checksum good
    logic        answer;     // Good and addressed to us
    logic [31:0] sh;         // Data shift out
    logic        dpar;       // Parity of data
    logic        dvalid;     // Validity to report
    logic        read_req;   // Request pulse
    logic [7:0]  req_vector; // Request vector
    logic        hdr_error;  // Error pulse
  } host_t;

  host_t      h;      // Registers
  host_t      next_h; // Next state
  logic [1:0] lines;  // Both wired lines, line1 on the left

  assign lines = {link.serial_irq_line1, link.serial_irq_line0};

  // Follow the message cycle by cycle
  always_comb begin
    logic [5:0] c; // Cycle ending at this edge
    logic [1:0] p; // Uninverted header pair
    logic [1:0] v; // Level for the next cycle
    c                = h.cyc + 6'h01;
    p                = ~lines;
    v                = LINES_IDLE;
    next_h           = h;
    next_h.read_req  = 1'b0;
    next_h.hdr_error = 1'b0;
    case (h.st)
      H_IDLE: begin
        // Arbitration start pattern opens a message
        if (lines == LINES_ARB) begin
          next_h.cyc = CYC_ARB;
          next_h.hck = 2'h0;
          next_h.st  = H_RUN;
        end
      end
      H_RUN: begin
        next_h.cyc = c;
        if (c >= CYC_DM && c <= CYC_DEST_LAST) begin
          next_h.hdr = {h.hdr[19:0], p};
          next_h.hck = ck_add(h.hck, p);
        end
        if (c == CYC_HCK) begin
          // Check, then decide whether to answer
          next_h.ck_ok      = (p == h.hck);
          next_h.answer     = (p == h.hck) && (h.hdr[7:0] == my_id);
          next_h.read_req   = (p == h.hck) && (h.hdr[7:0] == my_id);
          next_h.req_vector = h.hdr[15:8];
          next_h.hdr_error  = (p != h.hck);
        end
        if (c == CYC_POST) begin
          v = ~(h.ck_ok ? STAT_OK : STAT_CKERR);
        end
        if (c == CYC_STAT0) begin
          next_h.sh     = reg_value;
          next_h.dpar   = ^reg_value;
          next_h.dvalid = reg_valid;
        end
        if (h.answer) begin
          if (c >= CYC_STAT1 && c < CYC_DATA_LAST) begin
            v         = h.sh[31:30];
            next_h.sh = {h.sh[29:0], 2'h0};
          end
          if (c == CYC_DATA_LAST) begin
            v = h.dvalid ? DSTAT_VALID : DSTAT_INVALID;
          end
          if (c == CYC_DSTAT) begin
            v = {2{h.dpar}};
          end
        end
        if (c == CYC_IDLE) begin
          next_h.st     = H_IDLE;
          next_h.cyc    = 6'h00;
          next_h.answer = 1'b0;
        end
      end
      default: begin
        next_h.st = H_IDLE;
      end
    endcase
    next_h.oe = ~v;
  end

  // State register
  always_ff @(posedge link.serial_irq_bus_clock or negedge reset_n) begin
    if (!reset_n) begin
      h <= '{st: H_IDLE, default: '0};
    end else begin
      h <= next_h;
    end
  end

  // Outputs straight from registers
  assign link.host_oe  = h.oe;
  assign link.host_out = 2'h0;
  assign read_req      = h.read_req;
  assign req_vector    = h.req_vector;
  assign hdr_error     = h.hdr_error;

endmodule : serial_irq_host_end

/* testbench/serial_irq_props.sv */
// Concurrent checks on the two-line serial interrupt bus
`timescale 1ns/1ps
module serial_irq_props (
  input wire logic       serial_irq_bus_clock, // Bus clock
  input wire logic       reset_n,              // Async reset, active low
  input wire logic [1:0] dev_out,              // Device drive level
  input wire logic [1:0] dev_oe,               // Device drive enable
  input wire logic [1:0] host_out,             // Responder drive level
  input wire logic [1:0] host_oe,              // Responder drive enable
  input wire logic       serial_irq_line0,     // Wired line 0
  input wire logic       serial_irq_line1      // Wired line 1
);
  logic [1:0] lines;    // Both lines, line 1 on the left
  logic [5:0] cyc;      // Cycle shown now, 0 outside a message
  logic [1:0] hck;      // Running header sum
  logic       par;      // Running data parity
  logic       resp;     // Responder pulled the status cycle
  logic       dat;      // Responder drove a data cycle
  logic       arb_seen; // Arbitration cycle on an idle bus
  assign lines    = {serial_irq_line1, serial_irq_line0};
  assign arb_seen = (cyc == 6'h00) && (lines == 2'h2);

  // Follow the message cycle by cycle and gather its sums
  always_ff @(posedge serial_irq_bus_clock or negedge reset_n) begin
    if (!reset_n) begin
      cyc  <= 6'h00;
      hck  <= 2'h0;
      dat  <= 1'b0;
      par  <= 1'b0;
      resp <= 1'b0;
    end else if (arb_seen) begin
      cyc  <= 6'h02;
      dat  <= 1'b0;
      hck  <= 2'h0;
      par  <= 1'b0;
      resp <= 1'b0;
    end else if (cyc != 6'h00) begin
      cyc <= (cyc == 6'h27) ? 6'h00 : cyc + 6'h01;
      if (cyc >= 6'h06 && cyc <= 6'h10) hck <= hck + ~lines;
      if (cyc >= 6'h15 && cyc <= 6'h24) par <= par ^ lines[1] ^ lines[0];
      if (cyc == 6'h13) resp <= (host_oe != 2'h0);
      if (cyc >= 6'h15 && cyc <= 6'h24 && host_oe != 2'h0) dat <= 1'b1;
    end
  end

  default clocking cb @(posedge serial_irq_bus_clock); endclocking
  default disable iff (!reset_n);
  sequence s_arb;
    arb_seen;
  endsequence
  sequence s_id;
    serial_irq_line0 [*4];
  endsequence
  sequence s_close;
    (lines == 2'h3) ##1 (cyc == 6'h00);
  endsequence

  a_id_frame: assert property (s_arb |=> s_id)
    else $error("id cycles without line 0 high");
  a_hdr_sum: assert property (cyc == 6'h11 |-> lines == ~hck)
    else $error("header checksum cycle wrong");
  a_post_idle: assert property (cyc == 6'h12 |-> lines == 2'h3)
    else $error("postamble not idle");
  a_status_pair: assert property (cyc == 6'h13 |-> lines[1] == lines[0])
    else $error("status cycle lines differ");
  a_dstat_pair: assert property (cyc == 6'h25 |-> lines[1] == lines[0])
    else $error("data status lines differ");
  a_data_ck: assert property (cyc == 6'h26 && dat |-> lines == {2{par}})
    else $error("data checksum wrong");
  a_msg_end: assert property (s_arb |-> ##38 s_close)
    else $error("message not closed at cycle 39");
  a_dev_quiet: assert property (cyc >= 6'h13 |-> dev_oe == 2'h0)
    else $error("device drives after header");
  a_host_quiet: assert property (cyc >= 6'h02 && cyc <= 6'h12 |-> host_oe == 2'h0)
    else $error("responder drives during header");
  a_no_answer: assert property (cyc >= 6'h15 && !resp |-> host_oe == 2'h0)
    else $error("silent responder drives data");
  a_open_drain: assert property (dev_out == 2'h0 && host_out == 2'h0)
    else $error("a driver pulls high");
endmodule : serial_irq_props

/* testbench/tb.sv */
// Self-checking bench: device end and responder end on one bus
`timescale 1ns/1ps
module tb;
  import serial_irq_pkg::*;
  logic        mclk, bclk, reset_n, rr_start, rr_busy, rr_done; // Core side
  logic [63:0] rr_entry, ent;       // Entry driven, entry expected
  logic [3:0]  rr_arb_id;           // Contender id
  logic [31:0] rr_data, reg_value, val; // Returned, offered, expected
  logic        rr_data_valid, reg_valid, vld, ans; // Validity flags
  logic [1:0]  rr_hdr_status;       // Status cycle value
  logic [23:0] irq_in, irq_mask;    // Boot interrupt inputs
  logic        legacy_boot_irq_n;   // Boot interrupt output
  logic [7:0]  my_id, req_vector;   // Responder id and request vector
  logic        read_req, hdr_error; // Responder pulses
  logic [1:0]  cap [1:39];          // Captured bus cycles
  int          n, num_errors, comparisons; // Capture count, counters
  int          rq, he;              // Responder pulses in one read

  serial_irq_link_if link (.serial_irq_bus_clock(bclk));
  serial_irq_dev_end serial_irq_dev_end_inst (.mclk(mclk),
    .reset_n(reset_n), .link(link), .rr_start(rr_start),
    .rr_entry(rr_entry), .rr_arb_id(rr_arb_id), .rr_busy(rr_busy),
    .rr_done(rr_done), .rr_data(rr_data), .rr_data_valid(rr_data_valid),
    .rr_hdr_status(rr_hdr_status), .irq_in(irq_in), .irq_mask(irq_mask),
    .legacy_boot_irq_n(legacy_boot_irq_n));
  serial_irq_host_end serial_irq_host_end_inst (.reset_n(reset_n),
    .link(link), .my_id(my_id), .reg_value(reg_value),
    .reg_valid(reg_valid), .read_req(read_req), .req_vector(req_vector),
    .hdr_error(hdr_error));
  serial_irq_props serial_irq_props_inst (.serial_irq_bus_clock(bclk),
    .reset_n(reset_n), .dev_out(link.dev_out), .dev_oe(link.dev_oe),
    .host_out(link.host_out), .host_oe(link.host_oe),
    .serial_irq_line0(link.serial_irq_line0),
    .serial_irq_line1(link.serial_irq_line1));

  // Clocks: edges every 4 and every 3 time units, meeting every 12
  always #4 mclk = ~mclk;
  always #3 bclk = ~bclk;

  // Record every bus cycle of one message from its arbitration cycle on
  always @(posedge bclk) begin
    if ((n == 0 && link.serial_irq_line1 && !link.serial_irq_line0) ||
        (n > 0 && n < 39)) begin
      cap[n + 1] <= {link.serial_irq_line1, link.serial_irq_line0};
      n <= n + 1;
    end
  end

  // Count the responder's pulses during one read
  always @(posedge bclk) begin
    if (read_req === 1'b1) rq <= rq + 1;
    if (hdr_error === 1'b1) he <= he + 1;
  end

  // Compare one result and count it
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Uninverted header pair of cycles 6 to 16
  function automatic logic [1:0] hdr(int c);
    case (c)
      6: return {ent[11], ent[10]};
      7: return ent[9:8];
      8: return {ent[14], ent[15]};
      default: return (c >= 13) ? ent[56 + 2 * (16 - c) +: 2]
                                : ent[2 * (12 - c) +: 2];
    endcase
  endfunction : hdr

  // Expected line pair of a bus cycle
  function automatic logic [1:0] exp_pair(int c);
    logic [1:0] s;
    s = 2'h0;
    for (int k = 6; k <= 16; k++) s = s + hdr(k);
    if (c == 1) return 2'h2;
    if (c <= 5) return {rr_arb_id[5 - c], 1'b1};
    if (c <= 16) return ~hdr(c);
    if (c == 17) return ~s;
    if (c == 19) return 2'h0;
    if (c >= 21 && c <= 36 && ans) return val[2 * (36 - c) +: 2];
    if (c == 37 && ans) return vld ? 2'h0 : 2'h3;
    if (c == 38 && ans) return {2{^val}};
    return 2'h3;
  endfunction : exp_pair

  // One remote read; a start held while busy must be dropped
  task automatic run_read(logic [63:0] e, logic [3:0] id, logic [31:0] v,
                          logic ok);
    int t;
    ent = e;
    val = v;
    vld = ok;
    ans = (e[63:56] == my_id);
    rr_entry = e;
    rr_arb_id = id;
    reg_value = v;
    reg_valid = ok;
    n = 0;
    rq = 0;
    he = 0;
    rr_start = 1'b1;
    @(posedge mclk);
    #0.7;
    cmp("rr_busy", 32'h1, rr_busy);
    @(posedge mclk);
    #0.7;
    rr_start = 1'b0;
    t = 0;
    while (rr_done !== 1'b1 && t < 500) begin
      @(posedge mclk);
      #0.7;
      t++;
    end
    if (t == 500) begin
      num_errors++;
      results();
    end
    cmp("rr_hdr_status", 32'h3, rr_hdr_status);
    cmp("rr_data_valid", {31'h0, ans & ok}, rr_data_valid);
    if (ans) cmp("rr_data", v, rr_data);
    if (ans) cmp("req_vector", {24'h0, e[7:0]}, req_vector);
    cmp("read_req count", {31'h0, ans}, rq);
    cmp("hdr_error count", 32'h0, he);
    for (int c = 1; c <= 39; c++)
      cmp($sformatf("bus cycle %0d", c), exp_pair(c), cap[c]);
    repeat (40) @(posedge mclk);
    #0.7;
    cmp("rr_busy idle", 32'h0, rr_busy);
  endtask : run_read

  // Boot interrupt follows the masked inputs only
  task automatic boot_case(logic [23:0] pins, logic [23:0] mask);
    irq_in = pins;
    irq_mask = mask;
    repeat (4) @(posedge mclk);
    #0.7;
    cmp("legacy_boot_irq_n", {31'h0, ~|(~pins & mask)}, legacy_boot_irq_n);
  endtask : boot_case

  // Print the counts and the verdict, then stop
  task automatic results();
    $display("Errors %0d of %0d comparisons", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // Main sequence
  initial begin
    mclk = 1'b0;
    bclk = 1'b0;
    reset_n = 1'b0;
    rr_start = 1'b0;
    rr_entry = 64'h0;
    rr_arb_id = 4'h0;
    irq_in = 24'hFFFFFF;
    irq_mask = 24'h0;
    my_id = 8'h5A;
    reg_value = 32'h0;
    reg_valid = 1'b0;
    num_errors = 0;
    comparisons = 0;
    n = 39;
    repeat (2) @(posedge mclk);
    #0.7;
    reset_n = 1'b1;
    cmp("legacy_boot_irq_n reset", 32'h1, legacy_boot_irq_n);
    cmp("rr_busy reset", 32'h0, rr_busy);
    run_read(64'h5A00_0000_0000_C7A5, 4'hA, 32'hA5C3_0F96, 1'b1);
    run_read(64'h5A00_0000_0000_3A3C, 4'h5, 32'h1234_5678, 1'b0);
    run_read(64'hA500_0000_0000_0B81, 4'h3, 32'h0F0F_0001, 1'b1);
    boot_case(24'hFFFFFF, 24'hFFFFFF);
    boot_case(24'h7FFFFF, 24'h800000);
    boot_case(24'hFFFFFE, 24'h7FFFFE);
    boot_case(24'hFFFFFE, 24'h000001);
    boot_case(24'h000000, 24'h000000);
    results();
  end
endmodule : tb
